// ==== i2csw_pkg.sv ====
`default_nettype none
package i2csw_pkg;
  // Channel count and register widths
  localparam int NCH = 4;
  localparam int NSYNC = 13;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_INFO = 8'h0C;
  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [4:0] STAT_RST = 5'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [12:0] SYNC_RST = 13'h1FFF;
  // Status field positions
  localparam int STAT_APPLY = 4;
  // Info field positions
  localparam int INFO_ASEL = 0;
  localparam int INFO_IRQ = 4;
  localparam int INFO_BUSY = 8;
  // Synchronised input vector positions
  localparam int S_SCL = 0;
  localparam int S_SDA = 1;
  localparam int S_RSTN = 2;
  localparam int S_ASEL = 3;
  localparam int S_IRQ = 5;
  localparam int S_DSDA = 9;
  // Serial target address base and bit counts
  localparam logic [6:0] DEV_ADDR_BASE = 7'h70;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // Clocks a released data line keeps echoing through the input filter
  localparam logic [2:0] ECHO_HOLD = 3'h5;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ADDR = 8'h02,
    ST_ACK_A = 8'h04,
    ST_WRITE = 8'h08,
    ST_ACK_W = 8'h10,
    ST_READ = 8'h20,
    ST_RACK = 8'h40,
    ST_IGNORE = 8'h80
  } i2csw_state_t;
  // Bus address from the two select pins
  function automatic logic [6:0] dev_addr(input logic [1:0] sel);
    dev_addr = DEV_ADDR_BASE | {5'h00, sel};
  endfunction : dev_addr
endpackage : i2csw_pkg
`default_nettype wire

// ==== i2csw_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2csw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  // Three stages; only agreeing late stages update the output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q_o <= RST;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o <= (s2_r & s3_r) | (q_o & (s2_r ^ s3_r)) | (s2_r & s3_r);
    end
  end
endmodule : i2csw_sync
`default_nettype wire

// ==== i2csw_chan.sv ====
`timescale 1ns/10ps
`default_nettype none
module i2csw_chan (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic en_i,
  input wire logic up_scl_i,
  input wire logic up_sda_i,
  input wire logic own_drive_i,
  input wire logic dn_sda_i,
  output logic dn_scl_oe_o,
  output logic dn_sda_oe_o,
  output logic up_pull_o
);
  logic down_nxt;
  logic up_nxt;
  logic [2:0] hold_r;
  // Direction lock: whoever pulled low first owns it, avoids latch-up;
  // no new claim while our own release still echoes, at the cost of a short delay
  always_comb begin
    down_nxt = !up_sda_i && !own_drive_i &&
               (dn_sda_oe_o || (!up_pull_o && hold_r == 3'h0));
    up_nxt = !dn_sda_i && !down_nxt && (up_pull_o || (!dn_sda_oe_o && hold_r == 3'h0));
  end
  // Echo hold-off, reloaded while any side is pulled low by us
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      hold_r <= 3'h0;
    end else if (ce_i) begin
      if (dn_sda_oe_o || up_pull_o || own_drive_i) begin
        hold_r <= i2csw_pkg::ECHO_HOLD;
      end else if (hold_r != 3'h0) begin
        hold_r <= hold_r - 3'h1;
      end
    end
  end
  // Pass gates; closed channels stay released
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      dn_scl_oe_o <= 1'b0;
      dn_sda_oe_o <= 1'b0;
      up_pull_o <= 1'b0;
    end else if (ce_i) begin
      dn_scl_oe_o <= !up_scl_i;
      dn_sda_oe_o <= down_nxt;
      up_pull_o <= up_nxt;
    end
  end
endmodule : i2csw_chan
`default_nettype wire

// ==== i2csw_top.sv ====
// Summary of operation
// - Upstream pair passes only to selected channels
// - Any channel combination, set by control register
// - Four active-low interrupt inputs, one per channel
// - Summary interrupt output is AND of inputs
// - Reset pin idles state machine, deselects all
// - Power-on reset does the same as pin
// - Control bit n selects channel n
// - Bus address 0x70 to 0x73 from selects
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
module i2csw_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_irq_o,
  input wire logic up_scl_i,
  input wire logic up_sda_i,
  output logic up_sda_o,
  output logic up_sda_oe_o,
  input wire logic reset_pin_n_i,
  input wire logic addr_sel_0_i,
  input wire logic addr_sel_1_i,
  input wire logic chan0_irq_in_n_i,
  input wire logic chan1_irq_in_n_i,
  input wire logic chan2_irq_in_n_i,
  input wire logic chan3_irq_in_n_i,
  output logic host_irq_n_o,
  output logic [3:0] downstream_clock_o,
  output logic [3:0] downstream_clock_oe_o,
  input wire logic [3:0] downstream_data_i,
  output logic [3:0] downstream_data_o,
  output logic [3:0] downstream_data_oe_o
);
  logic [12:0] raw;
  logic [12:0] syn;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic pin_rst;
  logic [3:0] irq_s;
  logic [3:0] irq_q;
  logic [3:0] ctrl_r;
  logic [3:0] pend_r;
  logic pend_v_r;
  logic [4:0] stat_r;
  logic [4:0] mask_r;
  logic [4:0] stat_set;
  logic [4:0] stat_clr;
  logic apply_ev;
  i2csw_pkg::i2csw_state_t st_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic rw_r;
  logic drive_r;
  logic [3:0] up_pull;
  logic wb_req;
  logic wb_wr;

  // Every pin from outside the clock domain is filtered here
  assign raw = {downstream_data_i, chan3_irq_in_n_i, chan2_irq_in_n_i, chan1_irq_in_n_i,
                chan0_irq_in_n_i, addr_sel_1_i, addr_sel_0_i, reset_pin_n_i, up_sda_i, up_scl_i};

  i2csw_sync #(
    .W(i2csw_pkg::NSYNC),
    .RST(i2csw_pkg::SYNC_RST)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(raw),
    .q_o(syn)
  );

  assign irq_s = syn[i2csw_pkg::S_IRQ +: 4];
  // pin reset level
  // A floating pin reads low and holds the block in reset
  assign pin_rst = !syn[i2csw_pkg::S_RSTN];

  // Previous line levels for edge and condition detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      irq_q <= 4'hF;
    end else if (ce_i) begin
      scl_q <= syn[i2csw_pkg::S_SCL];
      sda_q <= syn[i2csw_pkg::S_SDA];
      irq_q <= irq_s;
    end
  end

  // Bus conditions from filtered lines
  assign scl_rise = syn[i2csw_pkg::S_SCL] && !scl_q;
  assign scl_fall = !syn[i2csw_pkg::S_SCL] && scl_q;
  assign start_ev = syn[i2csw_pkg::S_SCL] && scl_q && sda_q && !syn[i2csw_pkg::S_SDA];
  assign stop_ev = syn[i2csw_pkg::S_SCL] && scl_q && !sda_q && syn[i2csw_pkg::S_SDA];
  assign apply_ev = stop_ev && pend_v_r;

  // power-on reset
  // Serial target state machine, answers on the upstream pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= i2csw_pkg::ST_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (ce_i) begin
      if (pin_rst || stop_ev) begin
        st_r <= i2csw_pkg::ST_IDLE;
        drive_r <= 1'b0;
      end else if (start_ev) begin
        st_r <= i2csw_pkg::ST_ADDR;
        cnt_r <= 4'h0;
        drive_r <= 1'b0;
      end else if (scl_rise) begin
        unique case (st_r)
          i2csw_pkg::ST_ADDR, i2csw_pkg::ST_WRITE: begin
            sh_r <= {sh_r[6:0], syn[i2csw_pkg::S_SDA]};
            cnt_r <= cnt_r + 4'h1;
          end
          i2csw_pkg::ST_READ: begin
            sh_r <= {sh_r[6:0], 1'b0};
            cnt_r <= cnt_r + 4'h1;
          end
          i2csw_pkg::ST_RACK: begin
            rw_r <= !syn[i2csw_pkg::S_SDA];
          end
          default: begin
            cnt_r <= cnt_r;
          end
        endcase
      end else if (scl_fall) begin
        unique case (st_r)
          i2csw_pkg::ST_ADDR: begin
            if (cnt_r == i2csw_pkg::BITS_PER_BYTE &&
                sh_r[7:1] == i2csw_pkg::dev_addr(syn[i2csw_pkg::S_ASEL +: 2])) begin
              st_r <= i2csw_pkg::ST_ACK_A;
              rw_r <= sh_r[0];
              drive_r <= 1'b1;
            end else if (cnt_r == i2csw_pkg::BITS_PER_BYTE) begin
              st_r <= i2csw_pkg::ST_IGNORE;
            end
          end
          i2csw_pkg::ST_ACK_A, i2csw_pkg::ST_ACK_W: begin
            cnt_r <= 4'h0;
            if (rw_r) begin
              st_r <= i2csw_pkg::ST_READ;
              sh_r <= {4'h0, ctrl_r};
              drive_r <= 1'b1;
            end else begin
              st_r <= i2csw_pkg::ST_WRITE;
              drive_r <= 1'b0;
            end
          end
          i2csw_pkg::ST_WRITE: begin
            if (cnt_r == i2csw_pkg::BITS_PER_BYTE) begin
              st_r <= i2csw_pkg::ST_ACK_W;
              drive_r <= 1'b1;
            end
          end
          i2csw_pkg::ST_READ: begin
            if (cnt_r == i2csw_pkg::BITS_PER_BYTE) begin
              st_r <= i2csw_pkg::ST_RACK;
              drive_r <= 1'b0;
            end else begin
              drive_r <= !sh_r[7];
            end
          end
          i2csw_pkg::ST_RACK: begin
            // Host ack starts the next byte at once; upper nibble is zero
            if (rw_r) begin
              st_r <= i2csw_pkg::ST_READ;
              sh_r <= {4'h0, ctrl_r};
              cnt_r <= 4'h0;
              drive_r <= 1'b1;
            end else begin
              st_r <= i2csw_pkg::ST_IGNORE;
            end
          end
          default: begin
            drive_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // pending selection
  // Written byte waits for the stop so a half transaction changes nothing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= i2csw_pkg::CTRL_RST;
      pend_v_r <= 1'b0;
    end else if (ce_i) begin
      if (pin_rst || stop_ev) begin
        pend_v_r <= 1'b0;
      end else if (st_r == i2csw_pkg::ST_WRITE && scl_fall &&
                   cnt_r == i2csw_pkg::BITS_PER_BYTE) begin
        pend_r <= sh_r[3:0];
        pend_v_r <= 1'b1;
      end
    end
  end

  // Wishbone slave: one wait state, ack drops after one cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= i2csw_pkg::CTRL_RST;
    end else if (ce_i) begin
      if (pin_rst) begin
        ctrl_r <= i2csw_pkg::CTRL_RST;
      end else if (apply_ev) begin
        ctrl_r <= pend_r;
      end else if (wb_wr && wb_adr_i == i2csw_pkg::OFF_CTRL) begin
        ctrl_r <= wb_dat_i[3:0];
      end
    end
  end

  // Sticky events: channel interrupt falls and applied selections
  assign stat_set = {apply_ev, irq_q & ~irq_s};
  assign stat_clr = (wb_wr && wb_adr_i == i2csw_pkg::OFF_STAT) ? wb_dat_i[4:0] : 5'h00;

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat_r <= i2csw_pkg::STAT_RST;
      mask_r <= i2csw_pkg::MASK_RST;
      wb_irq_o <= 1'b0;
    end else if (ce_i) begin
      stat_r <= (stat_r & ~stat_clr) | stat_set;
      if (wb_wr && wb_adr_i == i2csw_pkg::OFF_MASK) begin
        mask_r <= wb_dat_i[4:0];
      end
      wb_irq_o <= |(stat_r & mask_r);
    end
  end

  // Read mux and ack; unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          i2csw_pkg::OFF_CTRL: wb_dat_o <= {28'h0000000, ctrl_r};
          i2csw_pkg::OFF_STAT: wb_dat_o <= {27'h0000000, stat_r};
          i2csw_pkg::OFF_MASK: wb_dat_o <= {27'h0000000, mask_r};
          i2csw_pkg::OFF_INFO: begin
            wb_dat_o <= 32'h0000_0000;
            wb_dat_o[i2csw_pkg::INFO_ASEL +: 2] <= syn[i2csw_pkg::S_ASEL +: 2];
            wb_dat_o[i2csw_pkg::INFO_IRQ +: 4] <= irq_s;
            wb_dat_o[i2csw_pkg::INFO_BUSY] <= st_r != i2csw_pkg::ST_IDLE;
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      host_irq_n_o <= 1'b1;
    end else if (ce_i) begin
      host_irq_n_o <= &irq_s;
    end
  end

  for (genvar n = 0; n < i2csw_pkg::NCH; n++) begin : g_ch
    i2csw_chan u_chan (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .en_i(ctrl_r[n]),
      .up_scl_i(syn[i2csw_pkg::S_SCL]),
      .up_sda_i(syn[i2csw_pkg::S_SDA]),
      .own_drive_i(drive_r),
      .dn_sda_i(syn[i2csw_pkg::S_DSDA + n]),
      .dn_scl_oe_o(downstream_clock_oe_o[n]),
      .dn_sda_oe_o(downstream_data_oe_o[n]),
      .up_pull_o(up_pull[n])
    );
  end

  // Open-drain: outputs only ever pull low
  assign downstream_clock_o = 4'h0;
  assign downstream_data_o = 4'h0;
  assign up_sda_o = 1'b0;
  assign up_sda_oe_o = drive_r || (|up_pull);

  ctrl_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_wr && ce_i && wb_adr_i == i2csw_pkg::OFF_CTRL && !pin_rst && !apply_ev
    |=> ctrl_r == $past(wb_dat_i[3:0]))
    else $error("control write not stored");
  gate_closed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (downstream_clock_oe_o & ~$past(ctrl_r)) == 4'h0)
    else $error("closed channel drives its clock");
  chan_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && ctrl_r == 4'h1 && !syn[i2csw_pkg::S_SCL] |=> downstream_clock_oe_o == 4'h1)
    else $error("value 1 does not select channel 0 alone");
  irq_and_a: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
    ##1 host_irq_n_o == $past(&irq_s))
    else $error("summary interrupt is not the AND");
  irq_stick_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && irq_q[2] && !irq_s[2] |=> stat_r[2])
    else $error("channel interrupt event lost");
  pin_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && pin_rst |=> ctrl_r == 4'h0 && st_r == i2csw_pkg::ST_IDLE)
    else $error("pin reset did not deselect");
  por_reset_a: assert property (@(posedge clk_i)
    rst_i |=> ctrl_r == 4'h0 && st_r == i2csw_pkg::ST_IDLE && !up_sda_oe_o)
    else $error("power-on reset did not deselect");
  addr_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pin_rst && !start_ev && !stop_ev && scl_fall && st_r == i2csw_pkg::ST_ADDR &&
    cnt_r == 4'h8 && sh_r[7:1] == {5'h1C, syn[i2csw_pkg::S_ASEL +: 2]}
    |=> st_r == i2csw_pkg::ST_ACK_A && up_sda_oe_o)
    else $error("own address not acknowledged");
  apply_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && apply_ev && !pin_rst |=> ctrl_r == $past(pend_r) && stat_r[4])
    else $error("selection not applied at stop");
  read_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !pin_rst && !start_ev && !stop_ev && scl_fall && rw_r &&
    st_r == i2csw_pkg::ST_ACK_A |=> sh_r == {4'h0, $past(ctrl_r)})
    else $error("read does not return control");
  i2c_write_c: cover property (@(posedge clk_i) disable iff (rst_i) apply_ev);
  i2c_read_c: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r == i2csw_pkg::ST_RACK);
  irq_c: cover property (@(posedge clk_i) disable iff (rst_i) wb_irq_o && !host_irq_n_o);
  pin_rst_c: cover property (@(posedge clk_i) disable iff (rst_i) pin_rst && ctrl_r != 4'h0);
endmodule : i2csw_top
`default_nettype wire

// ==== i2csw_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// Upstream host on the switch's serial port
module i2csw_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o
);
  // Both lines released; the clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Start condition: data falls while clock high
  task automatic start();
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(1);
  endtask : start
  // 800 ns bit: 5 clocks low, 3 high, so device answers settle before the sample
  task automatic bitx(input logic b, output logic r);
    sda_oe_o <= ~b;
    tick(4);
    scl_o <= 1'b1;
    tick(3);
    r = sda_i;
    scl_o <= 1'b0;
    tick(1);
  endtask : bitx
  // Eight bits MSB first, then the acknowledge bit
  task automatic bytex(input logic [7:0] b, input logic ab, output logic [7:0] r,
                       output logic ak);
    for (int i = 7; i >= 0; i--) bitx(b[i], r[i]);
    bitx(ab, ak);
  endtask : bytex
  // Stop condition: data rises while clock high
  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    sda_oe_o <= 1'b0;
    tick(8);
  endtask : stop
endmodule : i2csw_host
`default_nettype wire

// ==== test_i2c_four_channel_switch.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_i2c_four_channel_switch;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, scl, host_oe, up_oe, rpin_n, mon_clr;
  logic [7:0] adr;
  logic [3:0] sel, cirq_n, dclk_oe, dsda_oe, seen_c, seen_d;
  logic [31:0] wdat, rdat, q;
  logic hirq_n;
  logic [1:0] asel;
  int n_fail, n_tests, n_cyc;
  // Open-drain lines with pull-ups; no downstream target answers
  wire up_sda = ~(host_oe | up_oe);
  wire [3:0] dsda = ~dsda_oe;

  i2csw_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_irq_o(irq), .up_scl_i(scl), .up_sda_i(up_sda), .up_sda_o(),
    .up_sda_oe_o(up_oe), .reset_pin_n_i(rpin_n), .addr_sel_0_i(asel[0]),
    .addr_sel_1_i(asel[1]), .chan0_irq_in_n_i(cirq_n[0]), .chan1_irq_in_n_i(cirq_n[1]),
    .chan2_irq_in_n_i(cirq_n[2]), .chan3_irq_in_n_i(cirq_n[3]), .host_irq_n_o(hirq_n),
    .downstream_clock_o(), .downstream_clock_oe_o(dclk_oe), .downstream_data_i(dsda),
    .downstream_data_o(), .downstream_data_oe_o(dsda_oe));
  i2csw_host host (.clk_i(clk_i), .sda_i(up_sda), .scl_o(scl), .sda_oe_o(host_oe));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Which channels ever got clock or data pulled low
  always @(posedge clk_i) begin
    seen_c <= mon_clr ? 4'h0 : seen_c | dclk_oe;
    seen_d <= mon_clr ? 4'h0 : seen_d | dsda_oe;
  end
  // Cut a hang short well past the expected run length
  always @(posedge clk_i) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 30000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic wait_clk(int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(logic [7:0] a, logic w, logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, 4'hF};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("wishbone ack", 32'h1, 32'h0);
    r = rdat;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic sw_wr(logic [6:0] a, logic [7:0] v, output logic [1:0] k);
    logic [7:0] r;
    host.start();
    host.bytex({a, 1'b0}, 1'b1, r, k[1]);
    host.bytex(v, 1'b1, r, k[0]);
    host.stop();
    wait_clk(8);
  endtask : sw_wr

  // Power-on values
  task automatic t_por();
    wb(i2csw_pkg::OFF_CTRL, 1'b0, 32'h0, q);
    chk("ctrl", 32'h0, q);
    chk("irq out", 32'h1, {31'h0, hirq_n});
  endtask : t_por
  // Selection decides which channels see traffic
  task automatic t_pass();
    logic [3:0] v[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};
    logic [1:0] k;
    foreach (v[i]) begin
      wb(i2csw_pkg::OFF_CTRL, 1'b1, {28'h0, v[i]}, q);
      mon_clr <= 1'b1;
      wait_clk(1);
      mon_clr <= 1'b0;
      sw_wr(7'h40, 8'h00, k);
      chk("clock pass", {28'h0, v[i]}, {28'h0, seen_c});
      chk("data pass", {28'h0, v[i]}, {28'h0, seen_d});
    end
  endtask : t_pass
  // Each select setting gives its own address; the address differing in bit 0 is ignored
  task automatic t_addr();
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      asel <= i[1:0];
      wait_clk(8);
      wb(i2csw_pkg::OFF_STAT, 1'b1, 32'h10, q);
      sw_wr(7'h70 | {5'h0, i[1:0]}, 8'h01 << i, k);
      chk("acks", 32'h0, {30'h0, k});
      wb(i2csw_pkg::OFF_CTRL, 1'b0, 32'h0, q);
      chk("ctrl", 32'h1 << i, q);
      wb(i2csw_pkg::OFF_STAT, 1'b0, 32'h0, q);
      chk("applied", 32'h1, {31'h0, q[i2csw_pkg::STAT_APPLY]});
      sw_wr(7'h70 | {5'h0, i[1:0] ^ 2'h1}, 8'h0F, k);
      chk("addr nack", 32'h1, {31'h0, k[1]});
      wb(i2csw_pkg::OFF_CTRL, 1'b0, 32'h0, q);
      chk("ctrl kept", 32'h1 << i, q);
    end
  endtask : t_addr
  // Serial read gives the present selection
  task automatic t_read();
    logic [1:0] k;
    logic [7:0] r;
    logic a;
    sw_wr(7'h73, 8'h0D, k);
    host.start();
    host.bytex(8'hE7, 1'b1, r, a);
    host.bytex(8'hFF, 1'b1, r, k[0]);
    host.stop();
    chk("read", 32'h00D, {23'h0, a, r});
  endtask : t_read
  // Summary output, sticky status, mask
  task automatic t_irq();
    wb(i2csw_pkg::OFF_MASK, 1'b1, 32'h1, q);
    for (int p = 0; p < 16; p++) begin
      cirq_n <= p[3:0];
      wait_clk(6);
      chk("summary", {31'h0, &p[3:0]}, {31'h0, hirq_n});
    end
    wb(i2csw_pkg::OFF_STAT, 1'b1, 32'h1F, q);
    cirq_n <= 4'hE;
    wait_clk(8);
    chk("irq set", 32'h1, {31'h0, irq});
    cirq_n <= 4'hF;
    wb(i2csw_pkg::OFF_STAT, 1'b1, 32'h1, q);
    wait_clk(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    cirq_n <= 4'hD;
    wait_clk(6);
    chk("irq masked", 32'h0, {31'h0, irq});
    wb(i2csw_pkg::OFF_STAT, 1'b0, 32'h0, q);
    chk("stat", 32'h2, q & 32'h1F);
    cirq_n <= 4'hF;
  endtask : t_irq
  // Reset pin, a second power-on reset, an unmapped place
  task automatic t_resets();
    wb(i2csw_pkg::OFF_CTRL, 1'b1, 32'hF, q);
    rpin_n <= 1'b0;
    wait_clk(8);
    rpin_n <= 1'b1;
    wait_clk(6);
    wb(i2csw_pkg::OFF_CTRL, 1'b0, 32'h0, q);
    chk("pin reset", 32'h0, q);
    wb(i2csw_pkg::OFF_CTRL, 1'b1, 32'hF, q);
    rst_i <= 1'b1;
    wait_clk(2);
    rst_i <= 1'b0;
    wb(i2csw_pkg::OFF_CTRL, 1'b0, 32'h0, q);
    chk("por again", 32'h0, q);
    wb(8'h10, 1'b1, 32'hF, q);
    wb(8'h10, 1'b0, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask : t_resets

  initial begin
    {rst_i, cyc, stb, we, mon_clr} = 5'h11;
    {adr, sel, wdat, asel, cirq_n, n_cyc} = '0;
    cirq_n = 4'hF;
    n_fail = 0;
    n_tests = 0;
    rpin_n = 1'b1;
    wait_clk(6);
    rst_i <= 1'b0;
    wait_clk(6);
    t_por();
    t_pass();
    t_addr();
    t_read();
    t_irq();
    t_resets();
    finish_test();
  end
endmodule : test_i2c_four_channel_switch
`default_nettype wire
